// ==== dv/pi_speed_loop_checker.sv ====
`timescale 1ns/1ps
module pi_speed_loop_checker
    import pi_loop_pkg::*;
#(
    parameter int SAMPLE_CLOCKS = SAMPLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [15:0] analog_in1,
    input wire logic [15:0] analog_in2,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] rated_current,
    input wire logic [15:0] dc_bus_volts,
    input wire logic [15:0] min_speed_level,
    input wire logic pi_mode,
    input wire logic drive_enable,
    input wire logic [15:0] speed_demand,
    input wire logic motor_output_enable,
    input wire logic standby_active
);
    // one clock domain, so clock and reset are given once here
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // read data only after a read
    property p_rd_idle; !reg_read |=> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_rd_speed; reg_read && reg_addr == 8'h24 |=> reg_rdata == $past(speed_demand); endproperty
    a_rd_speed: assert property (p_rd_speed) else $error("speed readback wrong");
    // status shows standby and output state
    property p_rd_status;
        reg_read && reg_addr == 8'h20 |=>
            reg_rdata[1:0] == {$past(motor_output_enable), $past(standby_active)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status readback wrong");
    // unmapped or unaligned reads give zero
    property p_rd_unmapped;
        reg_read && (reg_addr[1:0] != 2'b00 || reg_addr[7:2] > 6'h0D) |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_limit; speed_demand <= FULL_SCALE; endproperty
    a_limit: assert property (p_limit) else $error("speed above full scale");
    property p_stby_off; standby_active |-> !motor_output_enable && speed_demand == 16'h0000; endproperty
    a_stby_off: assert property (p_stby_off) else $error("output active in standby");
    // standby only entered from minimum speed
    property p_stby_entry; $rose(standby_active) |-> $past(speed_demand <= min_speed_level); endproperty
    a_stby_entry: assert property (p_stby_entry) else $error("standby from above minimum");
    // run command low stops everything next cycle
    property p_disable;
        !drive_enable |=> speed_demand == 16'h0000 && !motor_output_enable && !standby_active;
    endproperty
    a_disable: assert property (p_disable) else $error("output while disabled");
    // output only follows an active run command
    property p_out_cause; motor_output_enable |-> $past(drive_enable); endproperty
    a_out_cause: assert property (p_out_cause) else $error("output without run command");
endmodule : pi_speed_loop_checker

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    import pi_loop_pkg::*;
    // short sample period keeps the standby delay to a few thousand cycles
    localparam int SC = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] analog_in1 = 16'h0258;
    logic [15:0] analog_in2 = 16'h00C8;
    logic [15:0] motor_current = 16'h0032;
    logic [15:0] rated_current = 16'h00C8;
    logic [15:0] dc_bus_volts = 16'h0190;
    logic [15:0] min_speed_level = 16'h0064;
    logic pi_mode = 1'b1;
    logic drive_enable = 1'b1;
    logic [15:0] speed_demand;
    logic motor_output_enable;
    logic standby_active;
    int error_cnt = 0;
    int check_count = 0;
    logic [15:0] dflt [8] = '{16'h000A, 16'h000A, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0032};
    logic [15:0] fbx [6] = '{16'h00C8, 16'h0258, 16'h00FA, 16'h0190, 16'h0190, 16'h0258};

    always #12.5 clock = ~clock;

    pi_speed_loop #(.SAMPLE_CLOCKS(SC)) u_dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .analog_in1(analog_in1), .analog_in2(analog_in2), .motor_current(motor_current),
        .rated_current(rated_current), .dc_bus_volts(dc_bus_volts),
        .min_speed_level(min_speed_level), .pi_mode(pi_mode), .drive_enable(drive_enable),
        .speed_demand(speed_demand), .motor_output_enable(motor_output_enable),
        .standby_active(standby_active)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle strobes, launched just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        // look mid-cycle while the data stand, then hand back on a rising edge
        @(negedge clock);
        chk(reg_rdata, e, what);
        @(posedge clock);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n * SC) @(posedge clock);
    endtask : ticks

    task automatic wait_sb(input logic v);
        int k;
        for (k = 0; k < 3000 && standby_active !== v; k++) @(posedge clock);
        if (k >= 3000) begin
            error_cnt++;
            end_of_test();
        end
    endtask : wait_sb

    task automatic sp_chk(input logic [15:0] a2, input logic [15:0] e, input string what);
        @(posedge clock);
        analog_in2 <= a2;
        ticks(3);
        chk(speed_demand, e, what);
    endtask : sp_chk

    // idle at zero speed into standby, hold below wake level, then wake
    task automatic stby(input logic [15:0] sense, input logic [15:0] e);
        wr(8'h08, sense);
        wr(8'h10, 16'h0000);
        @(posedge clock);
        analog_in2 <= 16'h01F4;
        ticks(90);
        chk({15'h0000, standby_active}, 16'h0000, "standby early");
        wait_sb(1'b1);
        chk({15'h0000, motor_output_enable}, 16'h0000, "output in standby");
        rd(8'h20, 16'h0005, "status");
        wr(8'h10, 16'h001E);
        @(posedge clock);
        analog_in2 <= 16'h0000;
        ticks(5);
        chk({15'h0000, standby_active}, 16'h0001, "standby below wake");
        wr(8'h10, 16'h003C);
        wait_sb(1'b0);
        repeat (2) @(posedge clock);
        chk(speed_demand, e, "wake speed");
        chk({15'h0000, motor_output_enable}, 16'h0001, "output after wake");
    endtask : stby

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int n = 0; n < 8; n++) rd(8'(n * 4), dflt[n], "default");
        rd(8'h3C, 16'h0000, "unmapped");
        wr(8'h00, 16'hFFFF);
        rd(8'h00, 16'h012C, "gain clamp");
        wr(8'h04, 16'h0000);
        for (int n = 0; n < 6; n++) begin
            wr(8'h14, 16'(n));
            ticks(2);
            rd(8'h28, fbx[n], "feedback");
        end
        rd(8'h2C, 16'h0258, "ain1 readback");
        rd(8'h30, 16'h00C8, "ain2 readback");
        analog_in1 <= 16'h00C8;
        analog_in2 <= 16'h0258;
        ticks(2);
        rd(8'h28, 16'h0258, "largest swapped");
        wr(8'h14, 16'h0004);
        ticks(2);
        rd(8'h28, 16'h0000, "difference floor");
        wr(8'h14, 16'h0000);
        wr(8'h00, 16'h000A);
        wr(8'h10, 16'h01F4);
        sp_chk(16'h00C8, 16'h012C, "direct");
        rd(8'h34, 16'h012C, "direct error");
        sp_chk(16'h0064, 16'h0190, "direct falling");
        wr(8'h08, 16'h0001);
        sp_chk(16'h0064, 16'h0000, "inverse low");
        rd(8'h34, 16'hFE70, "inverse error");
        sp_chk(16'h0320, 16'h012C, "inverse");
        sp_chk(16'h02BC, 16'h00C8, "inverse falling");
        rd(8'h24, 16'h00C8, "speed reg");
        wr(8'h08, 16'h0003);
        sp_chk(16'h0320, 16'h012C, "sense 3 inverse");
        wr(8'h08, 16'h0000);
        wr(8'h0C, 16'h0001);
        wr(8'h00, 16'h0014);
        analog_in1 <= 16'h02BC;
        sp_chk(16'h00C8, FULL_SCALE, "analog setpoint");
        // integral only, after a stop has cleared it
        wr(8'h0C, 16'h0000);
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h000A);
        drive_enable <= 1'b0;
        analog_in2 <= 16'h0000;
        repeat (2) @(posedge clock);
        chk(speed_demand, 16'h0000, "stopped");
        drive_enable <= 1'b1;
        ticks(100);
        chk({15'h0000, speed_demand >= 16'h002D && speed_demand <= 16'h0032},
            16'h0001, "integral");
        // standby with full-scale and ramped wake
        wr(8'h04, 16'h0000);
        wr(8'h00, 16'h000A);
        ticks(2);
        wr(8'h18, 16'h0001);
        stby(16'h0002, FULL_SCALE);
        stby(16'h0000, 16'h0000);
        // a mid-run reset brings the settings back to their defaults
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'h10, SETPOINT_RST, "setpoint after reset");
        rd(8'h18, STBY_TIME_RST, "standby time after reset");
        chk(speed_demand, 16'h0000, "speed after reset");
        end_of_test();
    end
endmodule : tb

bind pi_speed_loop pi_speed_loop_checker #(.SAMPLE_CLOCKS(SAMPLE_CLOCKS)) u_chk (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .analog_in1,
    .analog_in2, .motor_current, .rated_current, .dc_bus_volts, .min_speed_level, .pi_mode,
    .drive_enable, .speed_demand, .motor_output_enable, .standby_active
);

// ==== pkg/pi_loop_pkg.sv ====
// Operation
// R1 - proportional gain 0.0 to 30.0 in tenths, default 1.0, scales error
// R2 - integral time 0.0 to 30.0 s in tenths, default 1.0, divides the integral
// R3 - sense 0 direct: falling feedback raises motor speed
// R4 - sense 1 inverse: falling feedback lowers motor speed
// R5 - senses 2 and 3 as 0 and 1, but wake presets output to full scale
// R6 - setpoint from digital reference when source is 0, analog input 1 when 1
// R7 - digital reference 0.0 to 100.0 percent, default 0.0, used only when selected
// R8 - feedback code 0 takes analog input 2, code 1 takes analog input 1
// R9 - feedback code 2 takes motor current as percent of rated current
// R10 - feedback code 3 takes dc bus voltage, 0 to 1000 V onto 0 to 100 percent
// R11 - feedback code 4 takes analog 1 minus analog 2, never below zero
// R12 - feedback code 5 takes the larger analog input
// R13 - nonzero standby time: after that long at minimum speed, stop output, flag standby
// R14 - in pi mode, stay in standby until error reaches wake level, default 5.0
// R15 - fixed sample period; output is gain times error plus integral, held 0 to 100
package pi_loop_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int CFG_COUNT = 8;

    // register word index; byte address is four times the index
    localparam logic [5:0] IDX_GAIN = 6'h00;
    localparam logic [5:0] IDX_ITIME = 6'h01;
    localparam logic [5:0] IDX_SENSE = 6'h02;
    localparam logic [5:0] IDX_SP_SRC = 6'h03;
    localparam logic [5:0] IDX_SETPOINT = 6'h04;
    localparam logic [5:0] IDX_FB_SRC = 6'h05;
    localparam logic [5:0] IDX_STBY_TIME = 6'h06;
    localparam logic [5:0] IDX_WAKE = 6'h07;
    localparam logic [5:0] IDX_STATUS = 6'h08;
    localparam logic [5:0] IDX_SPEED = 6'h09;
    localparam logic [5:0] IDX_FEEDBACK = 6'h0A;
    localparam logic [5:0] IDX_AIN1 = 6'h0B;
    localparam logic [5:0] IDX_AIN2 = 6'h0C;
    localparam logic [5:0] IDX_ERROR = 6'h0D;

    // upper limits of the writable settings; codes plain, the rest in tenths
    localparam logic [15:0] GAIN_MAX = 16'h012C;
    localparam logic [15:0] ITIME_MAX = 16'h012C;
    localparam logic [15:0] SENSE_MAX = 16'h0003;
    localparam logic [15:0] SP_SRC_MAX = 16'h0001;
    localparam logic [15:0] SETPOINT_MAX = 16'h03E8;
    localparam logic [15:0] FB_SRC_MAX = 16'h0005;
    localparam logic [15:0] STBY_TIME_MAX = 16'h00FA;
    localparam logic [15:0] WAKE_MAX = 16'h03E8;

    // reset values
    localparam logic [15:0] GAIN_RST = 16'h000A;
    localparam logic [15:0] ITIME_RST = 16'h000A;
    localparam logic [15:0] SENSE_RST = 16'h0000;
    localparam logic [15:0] SP_SRC_RST = 16'h0000;
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    localparam logic [15:0] FB_SRC_RST = 16'h0000;
    localparam logic [15:0] STBY_TIME_RST = 16'h0000;
    localparam logic [15:0] WAKE_RST = 16'h0032;

    // percent values are carried in tenths: 1000 is full scale
    localparam logic [15:0] FULL_SCALE = 16'h03E8;
    localparam int GAIN_SCALE = 10;
    localparam int DC_BUS_FULL_VOLTS = 1000;

    // field positions
    localparam int SENSE_INVERSE_BIT = 0;
    localparam int SENSE_WAKE_FULL_BIT = 1;
    localparam int STAT_STANDBY_BIT = 0;
    localparam int STAT_OUTPUT_EN_BIT = 1;
    localparam int STAT_RUN_BIT = 2;

    // feedback source codes
    localparam logic [2:0] FB_AIN2 = 3'h0;
    localparam logic [2:0] FB_AIN1 = 3'h1;
    localparam logic [2:0] FB_CURRENT = 3'h2;
    localparam logic [2:0] FB_DC_BUS = 3'h3;
    localparam logic [2:0] FB_DIFF = 3'h4;
    localparam logic [2:0] FB_LARGEST = 3'h5;

    // timing
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLOCK_PERIOD_NS;
    localparam int TENTH_SECOND_US = 100000;
    localparam int SAMPLES_PER_TENTH = TENTH_SECOND_US / SAMPLE_PERIOD_US;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_STANDBY = 2'b10
    } loop_state_e;

    typedef struct packed {
        logic [CFG_COUNT-1:0][DATA_W-1:0] cfg;
        loop_state_e state;
        logic [15:0] sample_cnt;
        logic [31:0] acc;
        logic [15:0] speed;
        logic [15:0] feedback;
        logic signed [17:0] error;
        logic [15:0] idle_samples;
        logic out_en;
        logic [DATA_W-1:0] rdata;
    } loop_s;

endpackage : pi_loop_pkg

// ==== rtl/pi_speed_loop.sv ====
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module pi_speed_loop
    import pi_loop_pkg::*;
#(
    parameter int SAMPLE_CLOCKS = SAMPLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [15:0] analog_in1,
    input wire logic [15:0] analog_in2,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] rated_current,
    input wire logic [15:0] dc_bus_volts,
    input wire logic [15:0] min_speed_level,
    input wire logic pi_mode,
    input wire logic drive_enable,
    output logic [15:0] speed_demand,
    output logic motor_output_enable,
    output logic standby_active
);

    loop_s r;
    loop_s next_r;

    logic [15:0] ain1;
    logic [15:0] ain2;
    logic [15:0] fb_value;
    logic [15:0] setpoint;
    logic signed [17:0] err;
    logic [31:0] integ_den;
    logic [31:0] acc_limit;
    logic [15:0] i_term;
    logic signed [34:0] p_product;
    logic signed [34:0] p_term;
    logic signed [35:0] out_sum;
    logic signed [33:0] acc_sum;
    logic [31:0] idle_limit;
    logic sample_tick;
    logic [5:0] reg_index;
    logic reg_aligned;
    logic wake_full;
    logic inverse;

    // hold any level to full scale; saturating keeps later sums in range
    function automatic logic [15:0] clamp_full(input logic signed [35:0] v);
        if (v < 36'sd0) begin
            clamp_full = 16'h0000;
        end else if (v > $signed({20'h0_0000, FULL_SCALE})) begin
            clamp_full = FULL_SCALE;
        end else begin
            clamp_full = v[15:0];
        end
    endfunction : clamp_full

    // upper limit of each writable setting
    function automatic logic [15:0] cfg_max(input logic [5:0] idx);
        case (idx)
            IDX_GAIN: cfg_max = GAIN_MAX;
            IDX_ITIME: cfg_max = ITIME_MAX;
            IDX_SENSE: cfg_max = SENSE_MAX;
            IDX_SP_SRC: cfg_max = SP_SRC_MAX;
            IDX_SETPOINT: cfg_max = SETPOINT_MAX;
            IDX_FB_SRC: cfg_max = FB_SRC_MAX;
            IDX_STBY_TIME: cfg_max = STBY_TIME_MAX;
            IDX_WAKE: cfg_max = WAKE_MAX;
            default: cfg_max = 16'h0000;
        endcase
    endfunction : cfg_max

    // analog inputs arrive in tenths of a percent; anything above full is full
    assign ain1 = clamp_full($signed({20'h0_0000, analog_in1}));
    assign ain2 = clamp_full($signed({20'h0_0000, analog_in2}));

    // feedback source mux
    always_comb begin
        fb_value = ain2;
        case (r.cfg[IDX_FB_SRC[2:0]][2:0])
            // R8 analog input pick
            FB_AIN2: fb_value = ain2;
            FB_AIN1: fb_value = ain1;
            // R9 current as percent
            FB_CURRENT: begin
                if (rated_current == 16'h0000) begin
                    fb_value = 16'h0000;
                end else begin
                    fb_value = clamp_full(36'(({20'h0_0000, motor_current}
                        * 36'(FULL_SCALE)) / {20'h0_0000, rated_current}));
                end
            end
            // R10 dc bus scaling
            FB_DC_BUS: begin
                fb_value = clamp_full(36'(({20'h0_0000, dc_bus_volts}
                    * 36'(FULL_SCALE)) / 36'(DC_BUS_FULL_VOLTS)));
            end
            // R11 difference floored zero
            FB_DIFF: fb_value = (ain1 > ain2) ? 16'(ain1 - ain2) : 16'h0000;
            // R12 larger analog input
            FB_LARGEST: fb_value = (ain1 > ain2) ? ain1 : ain2;
            default: fb_value = ain2;
        endcase
    end

    // R6 setpoint source select
    // R7 digital reference used
    assign setpoint = r.cfg[IDX_SP_SRC[2:0]][0] ? ain1 : r.cfg[IDX_SETPOINT[2:0]];

    assign inverse = r.cfg[IDX_SENSE[2:0]][SENSE_INVERSE_BIT];
    assign wake_full = r.cfg[IDX_SENSE[2:0]][SENSE_WAKE_FULL_BIT];

    // error is signed so that overshoot pulls the output back down
    always_comb begin
        if (inverse) begin
            // R4 inverse sense error
            err = $signed({2'b00, fb_value}) - $signed({2'b00, setpoint});
        end else begin
            // R3 direct sense error
            err = $signed({2'b00, setpoint}) - $signed({2'b00, fb_value});
        end
    end

    // R2 integral time divides
    assign integ_den = 32'(SAMPLES_PER_TENTH) * {16'h0000, r.cfg[IDX_ITIME[2:0]]};
    assign acc_limit = 32'({16'h0000, FULL_SCALE} * integ_den);
    assign i_term = (integ_den == 32'h0000_0000) ? 16'h0000 : 16'(r.acc / integ_den);

    // R1 gain in tenths
    assign p_product = $signed({1'b0, r.cfg[IDX_GAIN[2:0]]}) * err;
    assign p_term = p_product / 35'sd10;

    // R15 output sum limited
    assign out_sum = 36'(p_term) + $signed({20'h0_0000, i_term});

    // integrator step; a zero time leaves the integral out entirely
    assign acc_sum = $signed({2'b00, r.acc}) + 34'(err);

    // samples at minimum speed before standby
    assign idle_limit = 32'(SAMPLES_PER_TENTH) * {16'h0000, r.cfg[IDX_STBY_TIME[2:0]]};

    // R15 fixed sample tick
    assign sample_tick = (r.sample_cnt == 16'(SAMPLE_CLOCKS - 1));

    assign reg_index = reg_addr[7:2];
    assign reg_aligned = (reg_addr[1:0] == 2'b00);

    // next state of the whole block
    always_comb begin
        next_r = r;

        // sample period counter runs at all times
        if (sample_tick) begin
            next_r.sample_cnt = 16'h0000;
        end else begin
            next_r.sample_cnt = 16'(r.sample_cnt + 16'h0001);
        end

        if (!drive_enable) begin
            // stopped: integral cleared so a new start ramps from zero
            next_r.state = ST_RUN;
            next_r.acc = 32'h0000_0000;
            next_r.speed = 16'h0000;
            next_r.idle_samples = 16'h0000;
            next_r.out_en = 1'b0;
        end else if (sample_tick) begin
            next_r.feedback = fb_value;
            next_r.error = err;
            case (r.state)
                ST_RUN: begin
                    next_r.out_en = 1'b1;
                    // R15 output from gain times error plus integral
                    next_r.speed = clamp_full(out_sum);
                    if (integ_den != 32'h0000_0000) begin
                        // anti-windup: keep the integral inside the output span
                        if (acc_sum < 34'sd0) begin
                            next_r.acc = 32'h0000_0000;
                        end else if (acc_sum > $signed({2'b00, acc_limit})) begin
                            next_r.acc = acc_limit;
                        end else begin
                            next_r.acc = acc_sum[31:0];
                        end
                    end
                    // R13 minimum speed timer
                    if ((r.cfg[IDX_STBY_TIME[2:0]] != 16'h0000)
                        && (r.speed <= min_speed_level)) begin
                        if ({16'h0000, r.idle_samples} + 32'h0000_0001 >= idle_limit) begin
                            // R13 enter standby
                            next_r.state = ST_STANDBY;
                            next_r.speed = 16'h0000;
                            next_r.out_en = 1'b0;
                            next_r.idle_samples = 16'h0000;
                        end else begin
                            next_r.idle_samples = 16'(r.idle_samples + 16'h0001);
                        end
                    end else begin
                        next_r.idle_samples = 16'h0000;
                    end
                end
                ST_STANDBY: begin
                    next_r.speed = 16'h0000;
                    next_r.out_en = 1'b0;
                    // R14 wake on error
                    if ((r.cfg[IDX_STBY_TIME[2:0]] == 16'h0000) || !pi_mode
                        || (err >= $signed({2'b00, r.cfg[IDX_WAKE[2:0]]}))) begin
                        next_r.state = ST_RUN;
                        next_r.out_en = 1'b1;
                        next_r.idle_samples = 16'h0000;
                        if (wake_full) begin
                            // R5 full scale restart
                            next_r.speed = FULL_SCALE;
                            next_r.acc = acc_limit;
                        end else begin
                            next_r.acc = 32'h0000_0000;
                        end
                    end
                end
                default: begin
                    next_r.state = ST_RUN;
                    next_r.out_en = 1'b0;
                end
            endcase
        end

        // register writes, limited to each setting's range
        if (reg_write && reg_aligned && (reg_index < 6'(CFG_COUNT))) begin
            if (reg_wdata > cfg_max(reg_index)) begin
                next_r.cfg[reg_index[2:0]] = cfg_max(reg_index);
            end else begin
                next_r.cfg[reg_index[2:0]] = reg_wdata;
            end
        end

        // read data stands only in the cycle after the strobe
        next_r.rdata = 16'h0000;
        if (reg_read && reg_aligned) begin
            case (reg_index)
                IDX_GAIN, IDX_ITIME, IDX_SENSE, IDX_SP_SRC,
                IDX_SETPOINT, IDX_FB_SRC, IDX_STBY_TIME, IDX_WAKE: begin
                    next_r.rdata = r.cfg[reg_index[2:0]];
                end
                IDX_STATUS: begin
                    next_r.rdata[STAT_STANDBY_BIT] = (r.state == ST_STANDBY);
                    next_r.rdata[STAT_OUTPUT_EN_BIT] = r.out_en;
                    next_r.rdata[STAT_RUN_BIT] = drive_enable;
                end
                IDX_SPEED: next_r.rdata = r.speed;
                IDX_FEEDBACK: next_r.rdata = r.feedback;
                IDX_AIN1: next_r.rdata = ain1;
                IDX_AIN2: next_r.rdata = ain2;
                IDX_ERROR: next_r.rdata = 16'(r.error);
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    // state register with synchronous reset to documented defaults
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.cfg[IDX_GAIN[2:0]] <= GAIN_RST;
            r.cfg[IDX_ITIME[2:0]] <= ITIME_RST;
            r.cfg[IDX_SENSE[2:0]] <= SENSE_RST;
            r.cfg[IDX_SP_SRC[2:0]] <= SP_SRC_RST;
            r.cfg[IDX_SETPOINT[2:0]] <= SETPOINT_RST;
            r.cfg[IDX_FB_SRC[2:0]] <= FB_SRC_RST;
            r.cfg[IDX_STBY_TIME[2:0]] <= STBY_TIME_RST;
            r.cfg[IDX_WAKE[2:0]] <= WAKE_RST;
            r.state <= ST_RUN;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops; standby_active decoded from the state register
    assign reg_rdata = r.rdata;
    assign speed_demand = r.speed;
    assign motor_output_enable = r.out_en;
    // R13 standby indication
    assign standby_active = (r.state == ST_STANDBY);

endmodule : pi_speed_loop
